//--- core/rcp_map.svh
// offsets, field positions and defaults for the reset/power-down block
`ifndef RCP_MAP_SVH
`define RCP_MAP_SVH
`define RCP_SLEEP_TRIG_IDX    8'h03
`define RCP_SLEEP_TRIG_ADDR   12'h00C
`define RCP_OPTION_ADDR       12'h010
`define RCP_CTRL_ADDR         12'h014
`define RCP_STATUS_ADDR       12'h018
`define RCP_CLEAR_ADDR        12'h01C
`define RCP_OPT_WORD_LOC      11'h7FC
`define RCP_OPT_DEFAULT       14'h3FFF
`define RCP_OPT_PROTECT       13
`define RCP_OPT_REUSE         12
`define RCP_OPT_UV_HI         11
`define RCP_OPT_UV_LO         10
`define RCP_OPT_PIN_RST       7
`define RCP_OPT_WDT_HI        6
`define RCP_OPT_WDT_LO        5
`define RCP_CTRL_SLOW_HALT    0
`define RCP_CTRL_WAKE_PIN     1
`define RCP_CTRL_WAKE_TMR     2
`define RCP_CTRL_SLEEP        3
`define RCP_REUSE_BASE        11'h400
`define RCP_HALF_TOP          11'h3FF
`define RCP_RSV_BASE          11'h7FC
`endif

//--- core/rcp_pkg.sv
// types shared by the reset/power-down block
package rcp_pkg;
   typedef enum logic [1:0] {PM_RUN, PM_IDLE, PM_STOP} rcp_mode_t;
   typedef struct packed {
      logic       protect_n;
      logic       reuse_n;
      logic [1:0] uv_sel;
      logic       pin_rst_en;
      logic [1:0] wdt_sel;
   } rcp_opt_t;
   typedef struct packed {
      logic       uv_reset_en;
      logic       uv_detect_en;
      logic [1:0] uv_level;
   } rcp_uv_t;
endpackage

//--- core/rcp_reset_ctrl.sv
// reset merge, option word decode and power-down control
//
// Contract
// - power-on, undervoltage, pin and watchdog resets each reset the chip
// - power-on reset returns all control registers to defaults
// - undervoltage reset holds chip in reset while supply is low
// - threshold field 00/01/10/11 picks 3.0/2.1/off/1.6 V levels
// - pin and watchdog resets are option-enabled and reset all registers; the code clears only ctrl_q and mode_q, cause_q and opt_q keep their values
// - option bit 7 enables pin reset, else pin is plain I/O
// - bits 6-5: 0x off, 10 run modes only, 11 always
// - option word lives at 7FCh, erased 3FFFh, programmer-only
// - option bit 13 low blocks program memory readout
// - protected, not re-use: only first half is protected
// - bit 12 cleared: protect all except reserved top area
// - re-use: reset vector 400h, interrupt vector 401h
// - sleep instruction enters idle or stop
// - power-down halts system clock and peripherals, timer optional
// - wake on reset, enabled pin/timer interrupt, or low port pins
// - any write to sleep trigger register enters power-down
// - slow halt set on entry selects stop mode
// - slow halt clear on entry selects idle mode
//
// Implementation choice: the AHB-Lite register port.
`timescale 1ns/1ps
`include "rcp_map.svh"
module rcp_reset_ctrl
   import rcp_pkg::*;
(
   input  wire logic        hclk,
   input  wire logic        hresetn,
   input  wire logic        hsel,
   input  wire logic [11:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic      [31:0] hrdata,
   output logic             hreadyout,
   output logic             hresp,
   input  wire logic        uv_below,
   input  wire logic        external_reset_pin,
   input  wire logic        wdt_expire,
   input  wire logic        cpu_sleep,
   input  wire logic [5:0]  porta_wake_pins,
   input  wire logic [5:0]  portb_wake_pins,
   input  wire logic        ext_int_req,
   input  wire logic        aux_timer_int_req,
   input  wire logic [13:0] factory_option_word,
   input  wire logic [10:0] fetch_addr,
   input  wire logic        readout_req,
   output logic             chip_reset_n,
   output rcp_uv_t          uv_cfg,
   output logic             readout_allow,
   output logic [10:0]      reset_vector,
   output logic [10:0]      irq_vector,
   output rcp_mode_t        power_mode,
   output logic             sys_clk_en,
   output logic             slow_clk_en,
   output logic             aux_timer_run
);
   // -------------------------------------------------------
   // input synchronisers
   // -------------------------------------------------------
   logic [3:0]  sy1_q, sy2_q;
   logic [11:0] wk1_q, wk2_q;
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         sy1_q <= 4'h0;
         sy2_q <= 4'h0;
         wk1_q <= 12'hFFF;
         wk2_q <= 12'hFFF;
      end else begin
         sy1_q <= {uv_below, ~external_reset_pin, wdt_expire, ext_int_req};
         sy2_q <= sy1_q;
         wk1_q <= {portb_wake_pins, porta_wake_pins};
         wk2_q <= wk1_q;
      end
   end
   wire uv_s   = sy2_q[3];
   wire pin_s  = sy2_q[2];
   wire wdt_s  = sy2_q[1];
   wire xint_s = sy2_q[0];

   // -------------------------------------------------------
   // option word capture and decode
   // -------------------------------------------------------
   logic [13:0] opt_q;
   logic        loaded_q;
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         opt_q    <= `RCP_OPT_DEFAULT;
         loaded_q <= 1'b0;
      end else if (!loaded_q) begin
         opt_q    <= factory_option_word; // read-only to firmware
         loaded_q <= 1'b1;
      end
   end
   rcp_opt_t opt;
   assign opt.protect_n  = opt_q[`RCP_OPT_PROTECT];
   assign opt.reuse_n    = opt_q[`RCP_OPT_REUSE];
   assign opt.uv_sel     = opt_q[`RCP_OPT_UV_HI:`RCP_OPT_UV_LO];
   assign opt.pin_rst_en = opt_q[`RCP_OPT_PIN_RST];
   assign opt.wdt_sel    = opt_q[`RCP_OPT_WDT_HI:`RCP_OPT_WDT_LO];

   // level code: 0 off, 1 = 1.6V, 2 = 2.1V, 3 = 3.0V
   assign uv_cfg.uv_reset_en  = (opt.uv_sel != 2'b10);
   assign uv_cfg.uv_detect_en = ~opt.uv_sel[1];
   assign uv_cfg.uv_level     = (opt.uv_sel == 2'b00) ? 2'd3 :
                                (opt.uv_sel == 2'b01) ? 2'd2 :
                                (opt.uv_sel == 2'b11) ? 2'd1 : 2'd0;

   // -------------------------------------------------------
   // reset merge
   // -------------------------------------------------------
   rcp_mode_t mode_q;
   wire in_pd   = (mode_q != PM_RUN);
   wire uv_rst  = uv_cfg.uv_reset_en & uv_s; // level, not pulse
   wire pin_rst = opt.pin_rst_en & pin_s;
   wire wdt_rst = wdt_s & opt.wdt_sel[1] &
                  (opt.wdt_sel[0] | ~in_pd);
   wire any_rst = loaded_q & (uv_rst | pin_rst | wdt_rst);
   logic [1:0] rel_q;
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn)
         rel_q <= 2'b00;
      else if (any_rst)
         rel_q <= 2'b00;
      else
         rel_q <= {rel_q[0], loaded_q}; // sync release
   end
   assign chip_reset_n = rel_q[1] & ~any_rst;
   wire soft_rst = ~chip_reset_n; // clears ctrl_q and mode_q below; cause_q keeps its bits

   // -------------------------------------------------------
   // protection and vectors
   // -------------------------------------------------------
   wire in_rsv  = (fetch_addr >= `RCP_RSV_BASE);
   wire in_half = (fetch_addr <= `RCP_HALF_TOP);
   wire prot_hit = ~opt.protect_n &
                   (opt.reuse_n ? in_half : ~in_rsv);
   assign readout_allow = readout_req & ~prot_hit;
   assign reset_vector = opt.reuse_n ? 11'h000 : `RCP_REUSE_BASE;
   assign irq_vector   = reset_vector + 11'h001;

   // -------------------------------------------------------
   // AHB-Lite slave
   // -------------------------------------------------------
   logic        wr_q, rd_q;
   logic [11:0] addr_q;
   logic [3:0]  ctrl_q;
   wire         take = hsel & hready & htrans[1];
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_q   <= 1'b0;
         rd_q   <= 1'b0;
         addr_q <= 12'h000;
      end else begin
         wr_q   <= take & hwrite;
         rd_q   <= take & ~hwrite;
         addr_q <= haddr;
      end
   end
   assign hreadyout = 1'b1;
   assign hresp     = 1'b0;
   wire wr_trig  = wr_q & (addr_q == `RCP_SLEEP_TRIG_ADDR);
   wire wr_ctrl  = wr_q & (addr_q == `RCP_CTRL_ADDR);
   wire wr_clear = wr_q & (addr_q == `RCP_CLEAR_ADDR);
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn)
         ctrl_q <= 4'h0;
      else if (soft_rst)
         ctrl_q <= 4'h0;
      else if (wr_ctrl)
         ctrl_q <= hwdata[3:0];
   end

   // -------------------------------------------------------
   // power-down sequencing
   // -------------------------------------------------------
   logic [2:0] cause_q;
   wire wake_pin = ~&wk2_q; // any low port pin
   wire wake_int = (ctrl_q[`RCP_CTRL_WAKE_PIN] & xint_s) |
                   (ctrl_q[`RCP_CTRL_WAKE_TMR] & aux_timer_int_req &
                    (mode_q == PM_IDLE));
   wire wake     = wake_pin | wake_int;
   wire enter    = cpu_sleep | wr_trig;
   rcp_mode_t mode_d;
   always_comb begin
      mode_d = mode_q;
      unique case (mode_q)
         PM_RUN:
            if (enter)
               mode_d = ctrl_q[`RCP_CTRL_SLOW_HALT] ? PM_STOP
                                                    : PM_IDLE;
         PM_IDLE:
            if (wake)
               mode_d = PM_RUN;
         PM_STOP:
            if (wake)
               mode_d = PM_RUN;
      endcase
   end
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn)
         mode_q <= PM_RUN;
      else if (soft_rst)
         mode_q <= PM_RUN; // reset wakes
      else
         mode_q <= mode_d;
   end
   // sticky reset-cause bits; set wins over clear
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn)
         cause_q <= 3'b000;
      else
         cause_q <= (cause_q & ~(wr_clear ? hwdata[2:0] : 3'b000)) |
                    {wdt_rst, pin_rst, uv_rst};
   end
   assign power_mode    = mode_q;
   assign sys_clk_en    = (mode_q == PM_RUN);
   assign slow_clk_en   = (mode_q != PM_STOP);
   assign aux_timer_run = (mode_q == PM_RUN) |
                          ((mode_q == PM_IDLE) &
                           ctrl_q[`RCP_CTRL_WAKE_TMR]);

   // -------------------------------------------------------
   // read mux
   // -------------------------------------------------------
   wire [31:0] rd_mux =
      (addr_q == `RCP_OPTION_ADDR) ? {18'h0_0000, opt_q} :
      (addr_q == `RCP_CTRL_ADDR)   ? {28'h000_0000, ctrl_q} :
      (addr_q == `RCP_STATUS_ADDR) ?
         {25'h000_0000, cause_q, 2'b00, mode_q} : 32'h0000_0000;
   assign hrdata = rd_q ? rd_mux : 32'h0000_0000;

   // -------------------------------------------------------
   // checks
   // -------------------------------------------------------
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);
   sequence s_enter_stop;
      (mode_q == PM_RUN) && enter && ctrl_q[0] && !soft_rst;
   endsequence
   sequence s_enter_idle;
      (mode_q == PM_RUN) && enter && !ctrl_q[0] && !soft_rst;
   endsequence
   sequence s_timer_wake;
      (mode_q == PM_IDLE) && ctrl_q[`RCP_CTRL_WAKE_TMR] &&
      aux_timer_int_req;
   endsequence
   a_stop_entry: assert property (
      s_enter_stop |=> mode_q == PM_STOP)
      else $error("stop not entered");
   a_idle_entry: assert property (
      s_enter_idle |=> mode_q == PM_IDLE)
      else $error("idle not entered");
   a_trig_sleep: assert property (
      wr_trig && mode_q == PM_RUN && !soft_rst |=> mode_q != PM_RUN)
      else $error("trigger write ignored");
   a_wake_pin: assert property (
      in_pd && wake_pin |=> mode_q == PM_RUN)
      else $error("pin wake missed");
   a_timer_wake: assert property (
      s_timer_wake |=> mode_q == PM_RUN)
      else $error("timer wake missed");
   a_uv_hold: assert property (
      uv_rst && loaded_q |-> !chip_reset_n)
      else $error("undervoltage not holding reset");
   a_uv_off: assert property (
      opt.uv_sel == 2'b10 |-> !uv_cfg.uv_reset_en && !uv_cfg.uv_detect_en)
      else $error("undervoltage not disabled");
   a_wdt_block: assert property (
      wdt_s && opt.wdt_sel == 2'b10 && in_pd |-> !wdt_rst)
      else $error("watchdog reset in power-down");
   a_wdt_always: assert property (
      wdt_s && opt.wdt_sel == 2'b11 && loaded_q |-> !chip_reset_n)
      else $error("watchdog reset missed");
   a_pin_gate: assert property (
      !opt.pin_rst_en |-> !pin_rst)
      else $error("pin reset while disabled");
   a_pin_reset: assert property (
      pin_s && opt.pin_rst_en && loaded_q |-> !chip_reset_n)
      else $error("pin reset missed");
   a_sync_rel: assert property (
      $rose(chip_reset_n) |-> $past(rel_q[0]))
      else $error("release not synchronous");
   a_ctrl_clear: assert property (
      soft_rst |=> ctrl_q == 4'h0)
      else $error("controls not defaulted");
   a_opt_default: assert property (
      !loaded_q |-> opt_q == `RCP_OPT_DEFAULT)
      else $error("option word not at erased value");
   a_reuse_vec: assert property (
      !opt.reuse_n |-> reset_vector == 11'h400 && irq_vector == 11'h401)
      else $error("re-use vectors wrong");
   a_read_open: assert property (
      opt.protect_n |-> readout_allow == readout_req)
      else $error("readout blocked while unprotected");
   a_prot_half: assert property (
      !opt.protect_n && opt.reuse_n && readout_req &&
      fetch_addr > 11'h3FF |-> readout_allow)
      else $error("second half blocked");
   a_prot_full: assert property (
      !opt.protect_n && !opt.reuse_n && !in_rsv |-> !readout_allow)
      else $error("re-use area not protected");
   a_clk_halt: assert property (
      in_pd |-> !sys_clk_en)
      else $error("clock runs in power-down");
   a_stop_osc: assert property (
      mode_q == PM_STOP |-> !slow_clk_en && !aux_timer_run)
      else $error("oscillator runs in stop");
   a_idle_slow: assert property (
      mode_q == PM_IDLE |-> slow_clk_en)
      else $error("slow clock halted in idle");
endmodule

//--- verif/rcp_cpu_model.sv
// cpu-side partner: sleep instruction pulse and reset pin
`timescale 1ns/1ps
module rcp_cpu_model (
   input  wire logic hclk,
   input  wire logic sleep_req,
   input  wire logic pin_low,
   output logic      cpu_sleep,
   output logic      external_reset_pin
);
   // sleep is one clock wide, pin is a plain level
   initial begin
      cpu_sleep = 1'b0;
      external_reset_pin = 1'b1;
      forever begin
         @(posedge hclk);
         cpu_sleep <= sleep_req & ~cpu_sleep;
         external_reset_pin <= ~pin_low;
      end
   end
endmodule

//--- verif/tb.sv
// testbench for the reset and power-down block
`timescale 1ns/1ps
`include "rcp_map.svh"
module tb;
   import rcp_pkg::*;
   logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp;
   logic [11:0] haddr;
   logic [1:0]  htrans;
   logic [31:0] hwdata, hrdata, r;
   logic        uv_below, pin_low, wdt_expire, sleep_req, cpu_sleep;
   logic        xpin, ext_int_req, tmr_req, allow, crst_n, rq;
   logic        sclk, slck, tmr_run;
   logic [5:0]  pa, pb;
   logic [13:0] opt, o;
   logic [10:0] fa, rv, iv;
   rcp_uv_t     uv;
   rcp_mode_t   pm;
   int          failures, num_checks;
   rcp_cpu_model rcp_cpu_model_inst (.hclk, .sleep_req, .pin_low,
      .cpu_sleep, .external_reset_pin(xpin));
   rcp_reset_ctrl rcp_reset_ctrl_inst (.hclk, .hresetn, .hsel, .haddr,
      .htrans, .hwrite, .hsize(3'b010), .hwdata, .hready(hreadyout),
      .hrdata, .hreadyout, .hresp, .uv_below, .external_reset_pin(xpin),
      .wdt_expire, .cpu_sleep, .porta_wake_pins(pa), .portb_wake_pins(pb),
      .ext_int_req, .aux_timer_int_req(tmr_req), .factory_option_word(opt),
      .fetch_addr(fa), .readout_req(rq), .chip_reset_n(crst_n),
      .uv_cfg(uv), .readout_allow(allow), .reset_vector(rv),
      .irq_vector(iv), .power_mode(pm), .sys_clk_en(sclk),
      .slow_clk_en(slck), .aux_timer_run(tmr_run));
   // ---------------------------------------------------------------
   // reference model and tasks
   // ---------------------------------------------------------------
   function automatic logic [3:0] uv_exp(input logic [1:0] s);
      case (s)
         2'b00:   return 4'hF;
         2'b01:   return 4'hE;
         2'b10:   return 4'h0;
         default: return 4'h9;
      endcase
   endfunction
   function automatic logic ok_exp(input logic [13:0] w,
                                   input logic [10:0] a,
                                   input logic        q);
      if (q !== 1'b1) return 1'b0;
      if (w[13]) return 1'b1;
      return w[12] ? (a > 11'h3FF) : (a >= 11'h7FC);
   endfunction
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      num_checks++;
      if (g !== e) begin
         failures++;
         $display("FAIL %0t got %h exp %h", $time, g, e);
      end
   endtask
   task automatic bus(input logic w, input logic [11:0] a,
                      input logic [31:0] d);
      hsel <= 1'b1;
      htrans <= 2'b10;
      haddr <= a;
      hwrite <= w;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'b00;
      hwdata <= d;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      r = hrdata;
   endtask
   task automatic do_rst(input logic [13:0] w);
      hresetn <= 1'b0;
      opt <= w;
      repeat (2) @(posedge hclk);
      hresetn <= 1'b1;
      repeat (4) @(posedge hclk);
   endtask
   task automatic wait_chk(input logic e);
      repeat (6) @(posedge hclk);
      chk(crst_n, e);
   endtask
   task automatic wmode(input rcp_mode_t e);
      for (int i = 0; i < 8 && pm !== e; i++) @(posedge hclk);
      chk(pm, e);
   endtask
   task automatic slp;
      sleep_req <= 1'b1;
      @(posedge hclk);
      sleep_req <= 1'b0;
   endtask
   task automatic complete_run;
      $display("checks %0d failures %0d", num_checks, failures);
      if (failures == 0 && num_checks > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   // ---------------------------------------------------------------
   // clock, watchdog, tests
   // ---------------------------------------------------------------
   initial begin
      hclk = 1'b0;
      forever #25 hclk = ~hclk;
   end
   initial begin
      #1ms;
      failures++;
      complete_run;
   end
   initial begin
      {hresetn, hsel, hwrite, uv_below, pin_low, wdt_expire, rq} = '0;
      {sleep_req, ext_int_req, tmr_req, haddr, htrans, hwdata} = '0;
      {pa, pb, opt, fa} = {12'hFFF, 14'h3FFF, 11'h0};
      void'($urandom(99));
      repeat (12) @(posedge hclk);
      hresetn <= 1'b1;
      repeat (4) @(posedge hclk);
      chk(crst_n, 1'b1);
      for (int i = 0; i < 16; i++) begin
         o = 14'($urandom);
         o[13:10] = i[3:0];
         do_rst(o);
         fa <= 11'($urandom);
         rq <= 1'($urandom);
         bus(1'b0, `RCP_OPTION_ADDR, 32'h0);
         chk(r, {18'h0, o});
         chk(uv, uv_exp(o[11:10]));
         chk(rv, o[12] ? 11'h000 : 11'h400);
         chk(iv, o[12] ? 11'h001 : 11'h401);
         chk(allow, ok_exp(o, fa, rq));
      end
      do_rst(14'h3BFF);
      bus(1'b1, `RCP_CTRL_ADDR, 32'h7);
      pin_low <= 1'b1;
      wait_chk(1'b0);
      pin_low <= 1'b0;
      wait_chk(1'b1);
      bus(1'b0, `RCP_CTRL_ADDR, 32'h0);
      chk(r, 32'h0);
      do_rst(14'h3B7F);
      pin_low <= 1'b1;
      wait_chk(1'b1);
      pin_low <= 1'b0;
      for (int s = 0; s < 4; s++) begin
         do_rst(14'h3B1F | 14'(s << 5));
         wdt_expire <= 1'b1;
         wait_chk(!s[1]);
         wdt_expire <= 1'b0;
         repeat (4) @(posedge hclk);
      end
      bus(1'b0, `RCP_STATUS_ADDR, 32'h0);
      chk(r, 32'h0000_0040);
      bus(1'b1, `RCP_CLEAR_ADDR, 32'h4);
      bus(1'b0, `RCP_STATUS_ADDR, 32'h0);
      chk(r, 32'h0000_0000);
      do_rst(14'h3B5F);
      slp;
      wmode(PM_IDLE);
      wdt_expire <= 1'b1;
      wait_chk(1'b1);
      wdt_expire <= 1'b0;
      do_rst(14'h33FF);
      uv_below <= 1'b1;
      wait_chk(1'b0);
      wait_chk(1'b0);
      uv_below <= 1'b0;
      wait_chk(1'b1);
      bus(1'b1, `RCP_CTRL_ADDR, 32'h0);
      slp;
      wmode(PM_IDLE);
      chk({sclk, slck}, 2'b01);
      pa[3] <= 1'b0;
      wmode(PM_RUN);
      pa <= 6'h3F;
      bus(1'b1, `RCP_CTRL_ADDR, 32'h1);
      bus(1'b1, `RCP_SLEEP_TRIG_ADDR, $urandom);
      wmode(PM_STOP);
      chk({sclk, slck}, 2'b00);
      pb[0] <= 1'b0;
      wmode(PM_RUN);
      pb <= 6'h3F;
      bus(1'b1, `RCP_CTRL_ADDR, 32'h4);
      slp;
      wmode(PM_IDLE);
      chk(tmr_run, 1'b1);
      tmr_req <= 1'b1;
      wmode(PM_RUN);
      tmr_req <= 1'b0;
      bus(1'b1, `RCP_CTRL_ADDR, 32'h3);
      slp;
      wmode(PM_STOP);
      ext_int_req <= 1'b1;
      wmode(PM_RUN);
      ext_int_req <= 1'b0;
      bus(1'b0, `RCP_SLEEP_TRIG_ADDR, 32'h0);
      chk(r, 32'h0);
      bus(1'b0, 12'h100, 32'h0);
      chk(r, 32'h0000_0000);
      chk(hresp, 32'h0000_0000);
      complete_run;
   end
endmodule
